// file: hdl/tcf_timer.v
`timescale 1ns/1ps
`include "tcf_consts.vh"

module tcf_timer (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire [5:0] io_addr_in,
  input  wire       io_wr_in,
  input  wire       io_rd_in,
  input  wire [7:0] io_wdata_in,
  input  wire       capture_input_pin_in,
  input  wire       external_count_pin_in,
  output reg  [7:0] io_rdata_out,
  output reg        compare_output_pin_a_out,
  output reg        compare_output_pin_b_out,
  output reg        compare_output_pin_c_out,
  output reg        capture_flag_out
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0]  timer_ctrl_a;
  reg [7:0]  timer_ctrl_b;
  reg [7:0]  temp_high;
  reg [15:0] counter_value;
  reg [15:0] compare_value_reg_a;
  reg [15:0] compare_value_reg_b;
  reg [15:0] compare_value_reg_c;
  reg [15:0] capture_value_reg;
  reg [3:0]  flags;
  reg        count_down;
  reg        block_match;
  reg [`TCF_PRESCALE_W-1:0] prescale;
  reg        cap_s1;
  reg        cap_s2;
  reg        ext_s1;
  reg        ext_s2;
  reg        ext_s3;
  reg        filt_d;
  wire       filt;

  // ----------------------------------------
  // Pin synchronisers and filter
  // ----------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_s1 <= 1'b0;
      cap_s2 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      filt_d <= 1'b0;
    end else begin
      cap_s1 <= capture_input_pin_in;
      cap_s2 <= cap_s1;
      ext_s1 <= external_count_pin_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      filt_d <= filt;
    end
  end

  tcf_capture_filter #(
    .SAMPLES (`TCF_FILTER_SAMPLES)
  ) u_filter (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .sample_in    (cap_s2),
    .enable_in    (timer_ctrl_b[`TCF_B_FILT_EN]),
    .filtered_out (filt)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire [3:0] wgm = {timer_ctrl_b[4:3], timer_ctrl_a[1:0]};
  wire non_pwm  = (wgm == 4'h0) || (wgm == 4'h4) ||
                  (wgm == 4'hC) || (wgm == 4'hD);
  wire dual     = (wgm != 4'h0) && (wgm <= 4'h3 ||
                  (wgm >= 4'h8 && wgm <= 4'hB));
  wire cap_top  = (wgm == 4'h8) || (wgm == 4'hA) ||
                  (wgm == 4'hC) || (wgm == 4'hE);
  reg  [15:0] top;

  always @* begin
    case (wgm)
      4'h1, 4'h5:              top = 16'h00FF;
      4'h2, 4'h6:              top = 16'h01FF;
      4'h3, 4'h7:              top = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF:  top = compare_value_reg_a;
      4'h8, 4'hA, 4'hC, 4'hE:  top = capture_value_reg;
      default:                 top = 16'hFFFF;
    endcase
  end

  // ----------------------------------------
  // Clock select and prescaler
  // ----------------------------------------
  reg tick;

  always @* begin
    case (timer_ctrl_b[2:0])
      3'h1:    tick = 1'b1;
      3'h2:    tick = (prescale[2:0] == 3'h7);
      3'h3:    tick = (prescale[5:0] == 6'h3F);
      3'h4:    tick = (prescale[7:0] == 8'hFF);
      3'h5:    tick = (prescale == 10'h3FF);
      3'h6:    tick = ~ext_s2 & ext_s3;
      3'h7:    tick = ext_s2 & ~ext_s3;
      default: tick = 1'b0;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale <= {`TCF_PRESCALE_W{1'b0}};
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire wr_ctrl_c = io_wr_in && (io_addr_in == `TCF_A_CTRL_C);
  wire wr_cnt_l  = io_wr_in && (io_addr_in == `TCF_A_CNT_L);
  wire wr_flags  = io_wr_in && (io_addr_in == `TCF_A_FLAGS);
  wire [15:0] wr_word = {temp_high, io_wdata_in};

  // ----------------------------------------
  // Compare and capture events
  // ----------------------------------------
  wire match_a = tick && !block_match &&
                 (counter_value == compare_value_reg_a);
  wire match_b = tick && !block_match &&
                 (counter_value == compare_value_reg_b);
  wire match_c = tick && !block_match &&
                 (counter_value == compare_value_reg_c);
  wire edge_hit = timer_ctrl_b[`TCF_B_EDGE_SEL] ?
                  (filt & ~filt_d) : (~filt & filt_d);
  wire capture_ev = edge_hit && !cap_top;
  wire top_hit = cap_top && tick && (counter_value == top);
  wire force_ok = wr_ctrl_c && non_pwm;
  wire at_bottom = tick && (counter_value == 16'h0000);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_value <= `TCF_RST_WORD;
      count_down    <= 1'b0;
      block_match   <= 1'b0;
    end else if (wr_cnt_l) begin
      counter_value <= wr_word;
      block_match   <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
      if (dual) begin
        if (count_down) begin
          if (counter_value == 16'h0000) begin
            count_down    <= 1'b0;
            counter_value <= counter_value + 16'h0001;
          end else begin
            counter_value <= counter_value - 16'h0001;
          end
        end else if (counter_value >= top) begin
          count_down    <= 1'b1;
          counter_value <= counter_value - 16'h0001;
        end else begin
          counter_value <= counter_value + 16'h0001;
        end
      end else if (counter_value == top) begin
        counter_value <= `TCF_RST_WORD;
      end else begin
        counter_value <= counter_value + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Compare output actions
  // ----------------------------------------
  function next_pin;
    input       cur;
    input [1:0] act;
    input       hit;
    input       force_hit;
    input       bottom;
    begin
      next_pin = cur;
      if (non_pwm) begin
        if (hit || force_hit) begin
          case (act)
            2'b01:   next_pin = ~cur;
            2'b10:   next_pin = 1'b0;
            2'b11:   next_pin = 1'b1;
            default: next_pin = cur;
          endcase
        end
      end else if (act[1]) begin
        if (dual) begin
          if (hit) begin
            next_pin = act[0] ^ count_down;
          end
        end else if (hit) begin
          next_pin = act[0];
        end else if (bottom) begin
          next_pin = ~act[0];
        end
      end
    end
  endfunction

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_output_pin_a_out <= 1'b0;
      compare_output_pin_b_out <= 1'b0;
      compare_output_pin_c_out <= 1'b0;
    end else begin
      compare_output_pin_a_out <= next_pin(compare_output_pin_a_out,
        timer_ctrl_a[7:6], match_a,
        force_ok && io_wdata_in[`TCF_B_FORCE_A], at_bottom);
      compare_output_pin_b_out <= next_pin(compare_output_pin_b_out,
        timer_ctrl_a[5:4], match_b,
        force_ok && io_wdata_in[`TCF_B_FORCE_B], at_bottom);
      compare_output_pin_c_out <= next_pin(compare_output_pin_c_out,
        timer_ctrl_a[3:2], match_c,
        force_ok && io_wdata_in[`TCF_B_FORCE_C], at_bottom);
    end
  end

  // ----------------------------------------
  // Flags, set wins over write-one clear
  // ----------------------------------------
  wire [3:0] flag_set = {match_c, match_b, match_a,
                         capture_ev || top_hit};
  wire [3:0] flag_clr = wr_flags ? io_wdata_in[3:0] : 4'h0;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags            <= 4'h0;
      capture_flag_out <= 1'b0;
    end else begin
      flags            <= (flags & ~flag_clr) | flag_set;
      capture_flag_out <= (flags[`TCF_F_CAPTURE] &
                           ~flag_clr[`TCF_F_CAPTURE]) |
                          flag_set[`TCF_F_CAPTURE];
    end
  end

  // ----------------------------------------
  // Register writes and temp byte
  // ----------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_ctrl_a        <= `TCF_RST_CTRL;
      timer_ctrl_b        <= `TCF_RST_CTRL;
      temp_high           <= 8'h00;
      compare_value_reg_a <= `TCF_RST_WORD;
      compare_value_reg_b <= `TCF_RST_WORD;
      compare_value_reg_c <= `TCF_RST_WORD;
      capture_value_reg   <= `TCF_RST_WORD;
    end else begin
      if (capture_ev) begin
        capture_value_reg <= counter_value;
      end
      if (io_wr_in) begin
        case (io_addr_in)
          `TCF_A_CTRL_A: timer_ctrl_a <= io_wdata_in;
          `TCF_A_CTRL_B:
            timer_ctrl_b <= io_wdata_in & `TCF_CTRL_B_MASK;
          `TCF_A_CNT_H, `TCF_A_CMPA_H, `TCF_A_CMPB_H,
          `TCF_A_CMPC_H, `TCF_A_CAP_H:
            temp_high <= io_wdata_in;
          `TCF_A_CMPA_L: compare_value_reg_a <= wr_word;
          `TCF_A_CMPB_L: compare_value_reg_b <= wr_word;
          `TCF_A_CMPC_L: compare_value_reg_c <= wr_word;
          `TCF_A_CAP_L:
            if (!capture_ev) begin
              capture_value_reg <= wr_word;
            end
          default: temp_high <= temp_high;
        endcase
      end else if (io_rd_in) begin
        case (io_addr_in)
          `TCF_A_CNT_L:  temp_high <= counter_value[15:8];
          `TCF_A_CMPA_L: temp_high <= compare_value_reg_a[15:8];
          `TCF_A_CMPB_L: temp_high <= compare_value_reg_b[15:8];
          `TCF_A_CMPC_L: temp_high <= compare_value_reg_c[15:8];
          `TCF_A_CAP_L:  temp_high <= capture_value_reg[15:8];
          default:       temp_high <= temp_high;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    case (io_addr_in)
      `TCF_A_CTRL_A: next_rdata = timer_ctrl_a;
      `TCF_A_CTRL_B: next_rdata = timer_ctrl_b;
      `TCF_A_CTRL_C: next_rdata = 8'h00;
      `TCF_A_CNT_L:  next_rdata = counter_value[7:0];
      `TCF_A_CMPA_L: next_rdata = compare_value_reg_a[7:0];
      `TCF_A_CMPB_L: next_rdata = compare_value_reg_b[7:0];
      `TCF_A_CMPC_L: next_rdata = compare_value_reg_c[7:0];
      `TCF_A_CAP_L:  next_rdata = capture_value_reg[7:0];
      `TCF_A_CNT_H, `TCF_A_CMPA_H, `TCF_A_CMPB_H,
      `TCF_A_CMPC_H, `TCF_A_CAP_H:
                     next_rdata = temp_high;
      `TCF_A_FLAGS:  next_rdata = {4'h0, flags};
      default:       next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_out <= next_rdata;
    end
  end
endmodule

// file: hdl/tcf_consts.vh
// Functional notes
// - Filter needs four equal capture samples.
// - Edge select: zero falling, one rising.
// - Capture copies counter, sets capture flag.
// - Capture-as-TOP modes disconnect capture pin.
// - Codes 0-5: stop, /1, /8, /64, /256, /1024.
// - Code 6 falling, 7 rising external edge.
// - External pin counts even when driven locally.
// - Force bits act only in non-PWM modes.
// - Force strobe makes immediate output compare action.
// - Force sets no flag, never clears counter.
// - Force bits always read zero.
// - Counter access atomic via shared temp byte.
// - Counter write blocks next compare match.
// - Compare registers continuously compared with counter.
// - Match flag set on following timer tick.
`ifndef TCF_CONSTS_VH
`define TCF_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TCF_A_CTRL_A 6'h00
`define TCF_A_CTRL_B 6'h01
`define TCF_A_CTRL_C 6'h02
`define TCF_A_CNT_L  6'h03
`define TCF_A_CNT_H  6'h04
`define TCF_A_CMPA_L 6'h05
`define TCF_A_CMPA_H 6'h06
`define TCF_A_CMPB_L 6'h07
`define TCF_A_CMPB_H 6'h08
`define TCF_A_CMPC_L 6'h09
`define TCF_A_CMPC_H 6'h0A
`define TCF_A_CAP_L  6'h0B
`define TCF_A_CAP_H  6'h0C
`define TCF_A_FLAGS  6'h0D

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TCF_B_FILT_EN   7
`define TCF_B_EDGE_SEL  6
`define TCF_CTRL_B_MASK 8'hDF
`define TCF_B_FORCE_A   7
`define TCF_B_FORCE_B   6
`define TCF_B_FORCE_C   5
`define TCF_F_CAPTURE   0
`define TCF_F_MATCH_A   1
`define TCF_F_MATCH_B   2
`define TCF_F_MATCH_C   3
`define TCF_RST_CTRL    8'h00
`define TCF_RST_WORD    16'h0000

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TCF_FILTER_SAMPLES 4
`define TCF_PRESCALE_W     10

`endif

// file: hdl/tcf_capture_filter.v
`timescale 1ns/1ps
`include "tcf_consts.vh"

// ----------------------------------------
// Capture noise filter
// ----------------------------------------
module tcf_capture_filter #(
  parameter SAMPLES = `TCF_FILTER_SAMPLES
) (
  input  wire ref_clk_in,
  input  wire rst_in,
  input  wire sample_in,
  input  wire enable_in,
  output reg  filtered_out
);
  reg [SAMPLES-1:0] history;
  wire all_one  = &history;
  wire all_zero = ~|history;

  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      history      <= {SAMPLES{1'b0}};
      filtered_out <= 1'b0;
    end else begin
      history <= {history[SAMPLES-2:0], sample_in};
      if (!enable_in) begin
        filtered_out <= sample_in;
      end else if (all_one) begin
        filtered_out <= 1'b1;
      end else if (all_zero) begin
        filtered_out <= 1'b0;
      end
    end
  end
endmodule

// file: verif/tcf_timer_props.sv
`timescale 1ns/1ps
`include "tcf_consts.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module tcf_timer_props (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire [5:0] io_addr_in,
  input wire       io_wr_in,
  input wire       io_rd_in,
  input wire [7:0] io_wdata_in,
  input wire [7:0] io_rdata_out,
  input wire       compare_output_pin_a_out,
  input wire       compare_output_pin_b_out,
  input wire       compare_output_pin_c_out,
  input wire       capture_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  reg  [7:0] ctl_a;
  reg  [7:0] ctl_b;
  reg  [2:0] idle;
  wire [3:0] mode = {ctl_b[4:3], ctl_a[1:0]};
  wire       pwm  = !(mode == 4'h0 || mode == 4'h4 || mode[3:1] == 3'h6);
  wire       frc  = io_wr_in && io_addr_in == `TCF_A_CTRL_C;
  wire       clr  = io_wr_in && io_addr_in == `TCF_A_FLAGS && io_wdata_in[0];
  wire [2:0] pins = {compare_output_pin_a_out, compare_output_pin_b_out,
                     compare_output_pin_c_out};
  // Shadow of control bytes; idle counts stopped cycles
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
      idle  <= 3'h0;
    end else begin
      if (io_wr_in && io_addr_in == `TCF_A_CTRL_A) ctl_a <= io_wdata_in;
      if (io_wr_in && io_addr_in == `TCF_A_CTRL_B) ctl_b <= io_wdata_in;
      if (ctl_b[2:0] != 3'h0) idle <= 3'h0;
      else if (idle != 3'h7) idle <= idle + 3'h1;
    end
  end
  AST_RD_HOLD: assert property (!io_rd_in |=> $stable(io_rdata_out))
    else $error("read data changed without a read");
  AST_CTRL_C_ZERO: assert property (
    io_rd_in && io_addr_in == `TCF_A_CTRL_C |=> io_rdata_out == 8'h00)
    else $error("control C read not zero");
  AST_CTRL_B_READ: assert property (
    io_rd_in && io_addr_in == `TCF_A_CTRL_B
    |=> io_rdata_out == (ctl_b & `TCF_CTRL_B_MASK))
    else $error("control B readback wrong");
  AST_FLAG_FALL: assert property ($fell(capture_flag_out) |-> $past(clr))
    else $error("capture flag fell without clear");
  AST_FLAG_READ: assert property (
    io_rd_in && io_addr_in == `TCF_A_FLAGS
    |=> io_rdata_out[0] == $past(capture_flag_out))
    else $error("flag read differs from capture flag");
  AST_FORCE_PWM: assert property (frc && pwm && idle == 3'h7
    |=> $stable(pins)) else $error("force acted in a PWM mode");
  AST_STOP_PINS: assert property (
    idle == 3'h7 && !frc && !$past(frc) |=> $stable(pins))
    else $error("compare pin moved while stopped");
  AST_TOP_NOCAP: assert property (
    mode[3] && !mode[0] && idle == 3'h7 |=> !$rose(capture_flag_out))
    else $error("capture in a capture-as-top mode");
endmodule

bind tcf_timer tcf_timer_props chk_u (
  .ref_clk_in               (ref_clk_in),
  .rst_in                   (rst_in),
  .io_addr_in               (io_addr_in),
  .io_wr_in                 (io_wr_in),
  .io_rd_in                 (io_rd_in),
  .io_wdata_in              (io_wdata_in),
  .io_rdata_out             (io_rdata_out),
  .compare_output_pin_a_out (compare_output_pin_a_out),
  .compare_output_pin_b_out (compare_output_pin_b_out),
  .compare_output_pin_c_out (compare_output_pin_c_out),
  .capture_flag_out         (capture_flag_out)
);

// file: verif/tcf_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Capture and count pin driver
// ----------------------------------------
module tcf_pin_model (
  input  wire ref_clk_in,
  output reg  capture_input_pin_out,
  output reg  external_count_pin_out
);
  initial capture_input_pin_out = 1'b0;
  initial external_count_pin_out = 1'b0;
  // Software-driven count pin, 4 cycles per transition
  task toggle_count(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        repeat (4) @(posedge ref_clk_in);
        #1 external_count_pin_out = !external_count_pin_out;
      end
    end
  endtask
  task drive_capture(input reg level, input integer cycles);
    begin
      @(posedge ref_clk_in);
      #1 capture_input_pin_out = level;
      repeat (cycles) @(posedge ref_clk_in);
    end
  endtask
endmodule

// file: verif/test_timer16_capture_clock_force_ctrl.sv
`timescale 1ns/1ps
`include "tcf_consts.vh"
module test_timer16_capture_clock_force_ctrl;
  reg         ref_clk_in  = 1'b0;
  reg         rst_in      = 1'b1;
  reg  [5:0]  io_addr_in  = 6'h00;
  reg         io_wr_in    = 1'b0;
  reg         io_rd_in    = 1'b0;
  reg  [7:0]  io_wdata_in = 8'h00;
  wire        capture_input_pin_in;
  wire        external_count_pin_in;
  wire [7:0]  io_rdata_out;
  wire        compare_output_pin_a_out;
  wire        compare_output_pin_b_out;
  wire        compare_output_pin_c_out;
  wire        capture_flag_out;
  wire [2:0]  pins = {compare_output_pin_a_out, compare_output_pin_b_out,
                      compare_output_pin_c_out};
  integer     fails = 0;
  integer     samples_checked = 0;
  integer     i;
  reg  [15:0] v;
  localparam [54:0] DIVS = {11'h400, 11'h100, 11'h040, 11'h008, 11'h001};
  always #50 ref_clk_in = !ref_clk_in;
  tcf_pin_model pin_u (
    .ref_clk_in             (ref_clk_in),
    .capture_input_pin_out  (capture_input_pin_in),
    .external_count_pin_out (external_count_pin_in)
  );
  tcf_timer dut_u (
    .ref_clk_in               (ref_clk_in),
    .rst_in                   (rst_in),
    .io_addr_in               (io_addr_in),
    .io_wr_in                 (io_wr_in),
    .io_rd_in                 (io_rd_in),
    .io_wdata_in              (io_wdata_in),
    .capture_input_pin_in     (capture_input_pin_in),
    .external_count_pin_in    (external_count_pin_in),
    .io_rdata_out             (io_rdata_out),
    .compare_output_pin_a_out (compare_output_pin_a_out),
    .compare_output_pin_b_out (compare_output_pin_b_out),
    .compare_output_pin_c_out (compare_output_pin_c_out),
    .capture_flag_out         (capture_flag_out)
  );
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge ref_clk_in);
      #1;
      io_addr_in = a;
      io_wdata_in = d;
      io_wr_in = 1'b1;
      @(posedge ref_clk_in);
      #1;
      io_wr_in = 1'b0;
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      @(posedge ref_clk_in);
      #1;
      io_addr_in = a;
      io_rd_in = 1'b1;
      @(posedge ref_clk_in);
      #1;
      io_rd_in = 1'b0;
      d = io_rdata_out;
    end
  endtask
  task wr16(input [5:0] a, input [15:0] d);
    begin
      wr(a + 6'h01, d[15:8]);
      wr(a, d[7:0]);
    end
  endtask
  task chk8(input [5:0] a, input [7:0] e);
    begin
      rd(a, v[7:0]);
      check({8'h00, v[7:0]}, {8'h00, e});
    end
  endtask
  task chk16(input [5:0] a, input [15:0] e);
    begin
      rd(a, v[7:0]);
      rd(a + 6'h01, v[15:8]);
      check(v, e);
    end
  endtask
  task chkf(input [3:0] e);
    begin
      rd(`TCF_A_FLAGS, v[7:0]);
      check({12'h000, v[3:0]}, {12'h000, e});
    end
  endtask
  task run(input [7:0] cs, input integer n);
    begin
      wr(`TCF_A_CTRL_B, cs);
      repeat (n) @(posedge ref_clk_in);
      wr(`TCF_A_CTRL_B, 8'h00);
    end
  endtask
  task finish_test;
    begin
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    fails = fails + 1;
    finish_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    for (i = 1; i <= 12; i = i + 1) chk8(i[5:0], 8'h00);
    wr(`TCF_A_CTRL_B, 8'hFF);
    chk8(`TCF_A_CTRL_B, 8'hDF);
    wr(`TCF_A_CTRL_B, 8'h00);
    wr(`TCF_A_CTRL_C, 8'h1F);
    chk8(`TCF_A_CTRL_C, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      wr16(`TCF_A_CMPA_L + {i[4:0], 1'b0}, 16'hA55A ^ {14'h0, i[1:0]});
      chk16(`TCF_A_CMPA_L + {i[4:0], 1'b0}, 16'hA55A ^ {14'h0, i[1:0]});
    end
    wr(`TCF_A_CMPA_H, 8'h77);
    chk16(`TCF_A_CMPA_L, 16'hA55A);
    wr16(`TCF_A_CNT_L, 16'h1234);
    repeat (20) @(posedge ref_clk_in);
    chk16(`TCF_A_CNT_L, 16'h1234);
    for (i = 1; i <= 5; i = i + 1) begin
      wr16(`TCF_A_CNT_L, 16'h0000);
      run(i[7:0], 8 * DIVS[11 * (i - 1) +: 11] - 1);
      rd(`TCF_A_CNT_L, v[7:0]);
      rd(`TCF_A_CNT_H, v[15:8]);
      check({15'h0000, v >= 16'h0008 && v <= 16'h0009}, 16'h0001);
    end
    wr16(`TCF_A_CNT_L, 16'h0000);
    wr(`TCF_A_CTRL_B, 8'h07);
    pin_u.toggle_count(7);
    repeat (8) @(posedge ref_clk_in);
    wr(`TCF_A_CTRL_B, 8'h06);
    chk16(`TCF_A_CNT_L, 16'h0004);
    pin_u.toggle_count(5);
    repeat (8) @(posedge ref_clk_in);
    wr(`TCF_A_CTRL_B, 8'h00);
    chk16(`TCF_A_CNT_L, 16'h0007);
    wr16(`TCF_A_CNT_L, 16'h0ABC);
    pin_u.drive_capture(1'b1, 10);
    chkf(4'h0);
    pin_u.drive_capture(1'b0, 10);
    chkf(4'h1);
    check({15'h0000, capture_flag_out}, 16'h0001);
    chk16(`TCF_A_CAP_L, 16'h0ABC);
    wr(`TCF_A_FLAGS, 8'h01);
    wr(`TCF_A_CTRL_B, 8'h40);
    wr16(`TCF_A_CNT_L, 16'h0BCD);
    pin_u.drive_capture(1'b1, 10);
    chk16(`TCF_A_CAP_L, 16'h0BCD);
    wr(`TCF_A_FLAGS, 8'h01);
    wr(`TCF_A_CTRL_B, 8'hC0);
    pin_u.drive_capture(1'b0, 10);
    pin_u.drive_capture(1'b1, 2);
    pin_u.drive_capture(1'b0, 10);
    chkf(4'h0);
    pin_u.drive_capture(1'b1, 10);
    chkf(4'h1);
    wr(`TCF_A_FLAGS, 8'h01);
    wr(`TCF_A_CTRL_B, 8'h18);
    pin_u.drive_capture(1'b0, 10);
    pin_u.drive_capture(1'b1, 10);
    chkf(4'h0);
    chk16(`TCF_A_CAP_L, 16'h0BCD);
    wr(`TCF_A_CTRL_B, 8'h00);
    wr(`TCF_A_CTRL_A, 8'h54);
    wr(`TCF_A_CTRL_C, 8'hE0);
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({13'h0000, pins}, 16'h0007);
    chk8(`TCF_A_CTRL_C, 8'h00);
    wr(`TCF_A_CTRL_A, 8'hA9);
    wr(`TCF_A_CTRL_C, 8'hE0);
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({13'h0000, pins}, 16'h0007);
    wr(`TCF_A_CTRL_B, 8'h08);
    wr(`TCF_A_CTRL_A, 8'h54);
    wr16(`TCF_A_CNT_L, 16'h0100);
    wr(`TCF_A_CTRL_C, 8'hE0);
    repeat (3) @(posedge ref_clk_in);
    #1;
    check({13'h0000, pins}, 16'h0000);
    chk16(`TCF_A_CNT_L, 16'h0100);
    chkf(4'h0);
    wr(`TCF_A_CTRL_A, 8'h00);
    wr16(`TCF_A_CMPA_L, 16'h0010);
    wr16(`TCF_A_CMPB_L, 16'h0012);
    wr16(`TCF_A_CMPC_L, 16'h0014);
    wr16(`TCF_A_CNT_L, 16'h000C);
    run(8'h01, 10);
    chkf(4'hE);
    wr(`TCF_A_FLAGS, 8'h0E);
    wr(`TCF_A_CTRL_B, 8'h01);
    wr16(`TCF_A_CNT_L, 16'h0010);
    run(8'h01, 4);
    chkf(4'hC);
    finish_test;
  end
endmodule
